// ===== rtl/dcpp_defs.svh
// Register offsets, field layouts, reset values and counts
`ifndef DCPP_DEFS_SVH
`define DCPP_DEFS_SVH
`define DCPP_PTR_W 16
`define DCPP_ADDR_W 8
`define DCPP_DATA_W 8
`define DCPP_BUF_DEPTH 2
`define DCPP_OFS_SRC_PROG 8'h00
`define DCPP_OFS_DST_PROG 8'h04
`define DCPP_OFS_EVT_SIZE 8'h08
`define DCPP_OFS_EVT_PROG 8'h0C
`define DCPP_OFS_STATUS 8'h10
`define DCPP_OFS_CONTROL 8'h14
`define DCPP_OFS_CELL_COUNT 8'h18
`define DCPP_RST_WORD 32'h0000_0000
`define DCPP_RST_FIELD 16'h0000
`define DCPP_BEAT_BYTES 16'h0001
`define DCPP_CTRL_TRIG_BIT 0
`define DCPP_CTRL_ABORT_BIT 1
`define DCPP_CTRL_MCLR_BIT 2
`define DCPP_STAT_ACTIVE_BIT 0
`define DCPP_STAT_HOLD_BIT 1
`define DCPP_STAT_MATCH_BIT 2
`define DCPP_STAT_PEND_BIT 3
`endif

// ===== rtl/dcpp_pkg.sv
// Types shared by the progress-pointer channel
package dcpp_pkg;
  `include "dcpp_defs.svh"

  typedef enum logic {
    DCPP_IDLE = 1'b0,
    DCPP_RUN = 1'b1
  } dcpp_phase_type;

  typedef struct packed {
    dcpp_phase_type phase;
    logic [`DCPP_PTR_W-1:0] cell_size;
    logic [`DCPP_PTR_W-1:0] cell_count;
    logic [31:0] rdata;
    logic src_ready;
    logic cell_done;
    logic match_seen;
    logic pending;
    logic sw_trig;
  } dcpp_top_type;
endpackage

// ===== rtl/dcpp_count_if.sv
// Control and value of one progress counter
`timescale 1ns/10ps
interface dcpp_count_if #(parameter int W = 16);
  logic clear;
  logic advance;
  logic [W-1:0] step;
  logic [W-1:0] limit;
  logic [W-1:0] value;
  logic reach;
  modport owner(output clear, advance, step, limit, input value, reach);
  modport counter(input clear, advance, step, limit, output value, reach);
endinterface

// ===== rtl/dcpp_progress_counter.sv
// Byte offset counter that wraps at a programmable span
`timescale 1ns/10ps
module dcpp_progress_counter #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  dcpp_count_if.counter cnt
);
  typedef struct packed {
    logic [W-1:0] value;
  } dcpp_cnt_state_type;

  dcpp_cnt_state_type state_reg;
  dcpp_cnt_state_type state_next;
  logic [W:0] sum;
  logic [W:0] span;

  // A zero limit stands for the full 2**W span
  always_comb begin
    sum = {1'b0, state_reg.value} + {1'b0, cnt.step};
    span = (cnt.limit == '0) ? {1'b1, {W{1'b0}}} : {1'b0, cnt.limit};
    cnt.reach = cnt.advance && (sum >= span);
    state_next = state_reg;
    if (cnt.clear) begin
      state_next.value = '0;
    end else if (cnt.advance) begin
      state_next.value = cnt.reach ? '0 : sum[W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign cnt.value = state_reg.value;
endmodule

// ===== rtl/dcpp_pair_buffer.sv
// Small shifting FIFO with valid and ready on both sides
`timescale 1ns/10ps
module dcpp_pair_buffer #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slot;
    logic [CW-1:0] count;
    logic valid;
  } dcpp_buf_state_type;

  dcpp_buf_state_type state_reg;
  dcpp_buf_state_type state_next;
  logic push;
  logic pop;
  logic [CW-1:0] idx;

  // in_ready looks at the next fill so a registered ready upstream is safe
  always_comb begin
    state_next = state_reg;
    pop = state_reg.valid && out_ready;
    push = in_valid && (state_reg.count != CW'(DEPTH));
    idx = state_reg.count - CW'(pop);
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        state_next.slot[i] = state_reg.slot[i+1];
      end
    end
    if (push) begin
      state_next.slot[idx] = in_data;
    end
    state_next.count = state_reg.count + CW'(push) - CW'(pop);
    state_next.valid = (state_next.count != '0);
    in_ready = (state_next.count != CW'(DEPTH));
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign out_valid = state_reg.valid;
  assign out_data = state_reg.slot[0];
endmodule

// ===== rtl/dcpp_channel.sv
// One DMA channel's source, destination and cell progress tracking
`timescale 1ns/10ps
module dcpp_channel
  import dcpp_pkg::*;
#(
  parameter int PTR_W = `DCPP_PTR_W,
  parameter int DATA_W = `DCPP_DATA_W,
  parameter int BUF_DEPTH = `DCPP_BUF_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [`DCPP_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [PTR_W-1:0] source_size_field,
  input wire logic [PTR_W-1:0] dest_size_field,
  input wire logic start_event,
  input wire logic pattern_mode,
  input wire logic pattern_match,
  input wire logic src_valid,
  input wire logic [DATA_W-1:0] src_data,
  output logic src_ready,
  output logic dst_valid,
  output logic [DATA_W-1:0] dst_data,
  input wire logic dst_ready,
  output logic [PTR_W-1:0] src_offset,
  output logic [PTR_W-1:0] dst_offset,
  output logic cell_active,
  output logic cell_done
);
  dcpp_top_type state_reg;
  dcpp_top_type state_next;

  dcpp_count_if #(.W(PTR_W)) src_cnt();
  dcpp_count_if #(.W(PTR_W)) dst_cnt();
  dcpp_count_if #(.W(PTR_W)) cell_cnt();

  logic accept;
  logic drain;
  logic pattern_hit;
  logic trigger;
  logic starting;
  logic cell_end;
  logic buf_in_ready;
  logic wr_size;
  logic wr_ctrl;

  dcpp_progress_counter #(.W(PTR_W)) u_src_ptr (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cnt(src_cnt)
  );

  dcpp_progress_counter #(.W(PTR_W)) u_dst_ptr (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cnt(dst_cnt)
  );

  dcpp_progress_counter #(.W(PTR_W)) u_cell_ptr (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cnt(cell_cnt)
  );

  // Two entries let the destination stall for a cycle with no lost byte
  dcpp_pair_buffer #(.W(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(accept),
    .in_data(src_data),
    .in_ready(buf_in_ready),
    .out_valid(dst_valid),
    .out_data(dst_data),
    .out_ready(dst_ready)
  );

  // Source side: one byte per accepted beat
  assign accept = src_valid && state_reg.src_ready;
  assign drain = dst_valid && dst_ready;
  assign pattern_hit = pattern_mode && pattern_match;
  assign trigger = start_event || state_reg.sw_trig;
  assign wr_size = reg_wr && (reg_addr == `DCPP_OFS_EVT_SIZE);
  assign wr_ctrl = reg_wr && (reg_addr == `DCPP_OFS_CONTROL);

  // Source pointer wraps within the programmed source size, zero = 65,536
  assign src_cnt.clear = pattern_hit;
  assign src_cnt.advance = accept;
  assign src_cnt.step = `DCPP_BEAT_BYTES;
  assign src_cnt.limit = source_size_field;

  assign dst_cnt.clear = 1'b0;
  assign dst_cnt.advance = drain;
  assign dst_cnt.step = `DCPP_BEAT_BYTES;
  assign dst_cnt.limit = dest_size_field;

  // The cell counter's wrap marks the last byte of the cell
  assign cell_cnt.clear = pattern_hit || starting;
  assign cell_cnt.advance = accept;
  assign cell_cnt.step = `DCPP_BEAT_BYTES;
  assign cell_cnt.limit = state_reg.cell_size;
  assign cell_end = cell_cnt.reach && !pattern_hit;

  always_comb begin
    state_next = state_reg;
    state_next.cell_done = 1'b0;
    state_next.sw_trig = 1'b0;
    state_next.rdata = `DCPP_RST_WORD;
    starting = 1'b0;

    if (wr_size) begin
      state_next.cell_size = reg_wdata[PTR_W-1:0];
    end
    if (wr_ctrl && reg_wdata[`DCPP_CTRL_TRIG_BIT]) begin
      state_next.sw_trig = 1'b1;
    end
    if (wr_ctrl && reg_wdata[`DCPP_CTRL_MCLR_BIT]) begin
      state_next.match_seen = 1'b0;
    end
    if (pattern_hit) begin
      state_next.match_seen = 1'b1;
    end

    // A trigger during a running cell is held for one start after the cell ends by size or match
    unique case (state_reg.phase)
      DCPP_IDLE: begin
        if (trigger || state_reg.pending) begin
          starting = 1'b1;
          state_next.pending = 1'b0;
          state_next.phase = DCPP_RUN;
        end
      end
      DCPP_RUN: begin
        if (trigger) begin
          state_next.pending = 1'b1;
        end
        if (cell_end) begin
          state_next.phase = DCPP_IDLE;
          state_next.cell_done = 1'b1;
          state_next.cell_count = state_reg.cell_count + 16'h0001;
        end else if (pattern_hit) begin
          state_next.phase = DCPP_IDLE;
        end
      end
    endcase

    // A trigger landing in the abort cycle is kept, not lost
    if (wr_ctrl && reg_wdata[`DCPP_CTRL_ABORT_BIT]) begin
      state_next.phase = DCPP_IDLE;
      state_next.pending = trigger;
    end
    if (reg_wr && (reg_addr == `DCPP_OFS_CELL_COUNT)) begin
      state_next.cell_count = `DCPP_RST_FIELD;
    end

    // Ready is registered, so it only opens when room is certain
    state_next.src_ready = (state_next.phase == DCPP_RUN) && buf_in_ready;

    // Read data stands for exactly the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        `DCPP_OFS_SRC_PROG:
          state_next.rdata = {16'h0000, src_cnt.value};
        `DCPP_OFS_DST_PROG:
          state_next.rdata = {16'h0000, dst_cnt.value};
        `DCPP_OFS_EVT_SIZE:
          state_next.rdata = {16'h0000, state_reg.cell_size};
        `DCPP_OFS_EVT_PROG:
          state_next.rdata = {16'h0000, cell_cnt.value};
        `DCPP_OFS_STATUS: begin
          state_next.rdata[`DCPP_STAT_ACTIVE_BIT] =
            (state_reg.phase == DCPP_RUN);
          state_next.rdata[`DCPP_STAT_HOLD_BIT] = dst_valid;
          state_next.rdata[`DCPP_STAT_MATCH_BIT] = state_reg.match_seen;
          state_next.rdata[`DCPP_STAT_PEND_BIT] = state_reg.pending;
        end
        `DCPP_OFS_CELL_COUNT:
          state_next.rdata = {16'h0000, state_reg.cell_count};
        default:
          state_next.rdata = `DCPP_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign src_ready = state_reg.src_ready;
  assign src_offset = src_cnt.value;
  assign dst_offset = dst_cnt.value;
  assign cell_active = (state_reg.phase == DCPP_RUN);
  assign cell_done = state_reg.cell_done;
endmodule

// ===== tb/dcpp_channel_monitor.sv
// Checker on the progress channel's ports
`timescale 1ns/10ps
`include "dcpp_defs.svh"
module dcpp_channel_monitor #(
  parameter int PTR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [`DCPP_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [PTR_W-1:0] source_size_field,
  input wire logic [PTR_W-1:0] dest_size_field,
  input wire logic pattern_mode,
  input wire logic pattern_match,
  input wire logic src_valid,
  input wire logic src_ready,
  input wire logic dst_valid,
  input wire logic dst_ready,
  input wire logic [PTR_W-1:0] src_offset,
  input wire logic [PTR_W-1:0] dst_offset,
  input wire logic cell_active,
  input wire logic cell_done
);
  logic [PTR_W-1:0] src_inc;
  logic [PTR_W-1:0] dst_inc;
  logic src_take;
  logic dst_take;
  logic hit;
  // Width of the sum wraps 65,535 to 0, matching a zero size field
  assign src_inc = src_offset + 1'b1;
  assign dst_inc = dst_offset + 1'b1;
  assign src_take = clk_en && src_valid && src_ready;
  assign dst_take = clk_en && dst_valid && dst_ready;
  assign hit = clk_en && pattern_mode && pattern_match;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  upper_zero_a: assert property (reg_rdata[31:16] == '0)
    else $error("upper read bits not zero");
  read_source_a: assert property (reg_rd && clk_en &&
    reg_addr == `DCPP_OFS_SRC_PROG |=> reg_rdata == {16'h0000,
    $past(src_offset)}) else $error("source read mismatch");
  read_quiet_a: assert property (clk_en && !reg_rd |=>
    reg_rdata == '0) else $error("read data outside read cycle");
  pattern_clear_a: assert property (hit |=> src_offset == '0)
    else $error("source not cleared on match");
  source_step_a: assert property (src_take && !hit |=>
    src_offset == (($past(src_inc) == $past(source_size_field)) ? '0 :
    $past(src_inc))) else $error("source step wrong");
  source_hold_a: assert property (!src_take && !hit |=>
    $stable(src_offset)) else $error("source moved without byte");
  dest_step_a: assert property (dst_take |=>
    dst_offset == (($past(dst_inc) == $past(dest_size_field)) ? '0 :
    $past(dst_inc))) else $error("destination step wrong");
  dest_hold_a: assert property (!dst_take |=> $stable(dst_offset))
    else $error("destination moved without byte");
  done_pulse_a: assert property (cell_done && clk_en |=>
    !cell_done) else $error("done longer than one cycle");
  done_cause_a: assert property ($rose(cell_done) |->
    $past(src_take)) else $error("done without last byte");
  cover property (cell_done);
  cover property (hit && cell_active);
  cover property (dst_valid && !dst_ready && !src_ready);
endmodule

// ===== tb/dcpp_stream_model.sv
// Source and destination stand-in at the channel's far side
`timescale 1ns/10ps
module dcpp_stream_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic src_en,
  input wire logic stall,
  input wire logic src_ready,
  output logic src_valid,
  output logic [7:0] src_data,
  output logic dst_ready
);
  logic [7:0] next_byte_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      next_byte_reg <= 8'h00;
    end else if (clk_en && src_valid && src_ready) begin
      next_byte_reg <= next_byte_reg + 8'h01;
    end
  end
  assign src_valid = src_en;
  // Idle line shows the inverse, so a stale byte never passes as fresh
  assign src_data = src_en ? next_byte_reg : ~next_byte_reg;
  assign dst_ready = ~stall;
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the progress channel
`timescale 1ns/10ps
`include "dcpp_defs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  logic ref_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, stall = 1'h0;
  logic reg_wr = 1'h0, reg_rd = 1'h0, start_event = 1'h0, src_en = 1'h0;
  logic pattern_mode = 1'h0, pattern_match = 1'h0;
  logic [`DCPP_ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [15:0] source_size_field = 16'h0000, dest_size_field = 16'h0000;
  logic [15:0] src_offset, dst_offset;
  logic [7:0] src_data, dst_data, exp_byte = 8'h00;
  logic src_valid, src_ready, dst_valid, dst_ready, cell_active, cell_done;
  int fails = 0, comparisons = 0, acc = 0, base;
  always #12.5 ref_clk = ~ref_clk;
  dcpp_channel u_dut (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .source_size_field, .dest_size_field,
    .start_event, .pattern_mode, .pattern_match, .src_valid, .src_data,
    .src_ready, .dst_valid, .dst_data, .dst_ready, .src_offset,
    .dst_offset, .cell_active, .cell_done);
  dcpp_stream_model u_far (.ref_clk, .rst, .clk_en, .src_en, .stall,
    .src_ready, .src_valid, .src_data, .dst_ready);
  // Bytes must leave in the order they entered, none lost on a stall
  always @(posedge ref_clk) begin
    if (clk_en && src_valid && src_ready)
      acc++;
    if (clk_en && dst_valid && dst_ready) begin
      `CHK(dst_data, exp_byte)
      exp_byte <= exp_byte + 8'h01;
    end
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge ref_clk);
  endtask
  task automatic trig();
    base = acc;
    @(posedge ref_clk);
    start_event <= 1'h1;
    @(posedge ref_clk);
    start_event <= 1'h0;
  endtask
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (cell_done !== 1'h1 && n < lim);
    if (cell_done !== 1'h1) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic t_regs();
    rchk(`DCPP_OFS_SRC_PROG, 32'h0000_0000);
    rchk(`DCPP_OFS_DST_PROG, 32'h0000_0000);
    rchk(`DCPP_OFS_EVT_SIZE, 32'h0000_0000);
    rchk(`DCPP_OFS_EVT_PROG, 32'h0000_0000);
    wr(`DCPP_OFS_SRC_PROG, 32'h0000_1234);
    rchk(`DCPP_OFS_SRC_PROG, 32'h0000_0000);
    wr(`DCPP_OFS_EVT_SIZE, 32'hFFFF_0003);
    rchk(`DCPP_OFS_EVT_SIZE, 32'h0000_0003);
    rchk(8'h1C, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_cell();
    trig();
    clk_en <= 1'h0;
    ticks(3);
    clk_en <= 1'h1;
    wait_done(20);
    `CHK(acc - base, 3)
    ticks(4);
    rchk(`DCPP_OFS_SRC_PROG, 32'h0000_0003);
    rchk(`DCPP_OFS_EVT_PROG, 32'h0000_0000);
    rchk(`DCPP_OFS_DST_PROG, 32'h0000_0003);
    $display("test cell done");
  endtask
  task automatic t_wrap();
    source_size_field <= 16'h0004;
    dest_size_field <= 16'h0005;
    stall <= 1'h1;
    wr(`DCPP_OFS_EVT_SIZE, 32'h0000_0006);
    trig();
    ticks(10);
    `CHK(src_ready, 1'h0)
    `CHK(cell_active, 1'h1)
    stall <= 1'h0;
    wait_done(40);
    `CHK(acc - base, 6)
    ticks(4);
    rchk(`DCPP_OFS_SRC_PROG, 32'h0000_0001);
    rchk(`DCPP_OFS_DST_PROG, 32'h0000_0004);
    $display("test wrap done");
  endtask
  task automatic t_max();
    source_size_field <= 16'h0000;
    dest_size_field <= 16'h0000;
    wr(`DCPP_OFS_EVT_SIZE, 32'h0000_0000);
    trig();
    wait_done(70000);
    `CHK(acc - base, 65536)
    ticks(4);
    rchk(`DCPP_OFS_SRC_PROG, 32'h0000_0001);
    $display("test max cell done");
  endtask
  task automatic t_pattern();
    wr(`DCPP_OFS_EVT_SIZE, 32'h0000_000A);
    pattern_mode <= 1'h1;
    trig();
    ticks(4);
    pattern_match <= 1'h1;
    ticks(1);
    pattern_match <= 1'h0;
    ticks(4);
    `CHK(cell_active, 1'h0)
    rchk(`DCPP_OFS_SRC_PROG, 32'h0000_0000);
    rchk(`DCPP_OFS_EVT_PROG, 32'h0000_0000);
    $display("test pattern done");
  endtask
  // Status, software trigger, held trigger, abort and cell count
  task automatic t_ctrl();
    pattern_mode <= 1'h0;
    stall <= 1'h1;
    rchk(`DCPP_OFS_STATUS, 32'h0000_0004);
    rchk(`DCPP_OFS_CELL_COUNT, 32'h0000_0003);
    wr(`DCPP_OFS_CONTROL, 32'h0000_0004);
    wr(`DCPP_OFS_CONTROL, 32'h0000_0001);
    trig();
    rchk(`DCPP_OFS_STATUS, 32'h0000_000B);
    wr(`DCPP_OFS_CONTROL, 32'h0000_0002);
    rchk(`DCPP_OFS_STATUS, 32'h0000_0002);
    `CHK(acc - base, 2)
    rchk(`DCPP_OFS_EVT_PROG, 32'h0000_0002);
    rchk(`DCPP_OFS_CONTROL, 32'h0000_0000);
    wr(`DCPP_OFS_CELL_COUNT, 32'h0000_0000);
    rchk(`DCPP_OFS_CELL_COUNT, 32'h0000_0000);
    stall <= 1'h0;
    ticks(4);
    $display("test control done");
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    ticks(3);
    rst <= 1'h0;
    src_en <= 1'h1;
    t_regs();
    t_cell();
    t_wrap();
    t_max();
    t_pattern();
    t_ctrl();
    wrap_up();
  end
endmodule
bind dcpp_channel dcpp_channel_monitor #(.PTR_W(PTR_W), .DATA_W(DATA_W))
  u_mon (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .source_size_field(source_size_field),
  .dest_size_field(dest_size_field), .pattern_mode(pattern_mode),
  .pattern_match(pattern_match), .src_valid(src_valid),
  .src_ready(src_ready), .dst_valid(dst_valid), .dst_ready(dst_ready),
  .src_offset(src_offset), .dst_offset(dst_offset),
  .cell_active(cell_active), .cell_done(cell_done));
